// [exec_pkg.sv]
`default_nettype none

package exec_pkg;

    // ------------------------------------------------------------------
    // Instruction encoding
    // ------------------------------------------------------------------
    localparam int          INSN_W          = 14;
    localparam int          DATA_W          = 8;
    localparam int          PC_W            = 13;
    localparam int          FADDR_W         = 7;
    localparam int          IMM_W           = 11;
    // Opcode of decrement-and-skip, bits 13:8.
    localparam logic [5:0]  OPC_DEC_SKIP    = 6'h0B;
    // Opcode of increment, bits 13:8.
    localparam logic [5:0]  OPC_INCR        = 6'h0A;
    // Opcode of the unconditional branch, bits 13:11.
    localparam logic [2:0]  OPC_BRANCH      = 3'h5;
    localparam int          DEST_BIT        = 7;
    localparam logic        DEST_ACC        = 1'h0;
    localparam logic        DEST_FILE       = 1'h1;
    // Latch bits copied into the upper program counter bits.
    localparam int          LATCH_HI        = 4;
    localparam int          LATCH_LO        = 3;
    localparam int          LATCH_W         = 5;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          SKIP_CYCLES     = 2;
    localparam int          BRANCH_CYCLES   = 2;
    localparam int          PLAIN_CYCLES    = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACC_RST         = 8'h00;
    localparam logic [12:0] PC_RST          = 13'h0000;

endpackage : exec_pkg

`default_nettype wire

// [insn_decode.sv]
`timescale 1ns/1ps
`default_nettype none

// Pure decoder of the three instructions handled by the executor.
module insn_decode (
    input  wire logic [13:0] insn_i,
    output logic             is_dec_skip_o,
    output logic             is_incr_o,
    output logic             is_branch_o,
    output logic             dest_file_o,
    output logic [6:0]       faddr_o,
    output logic [10:0]      imm_o
);

    // Opcode match on the upper bits; the operand bits pass straight through.
    always_comb begin
        is_dec_skip_o = (insn_i[13:8] == exec_pkg::OPC_DEC_SKIP);
        is_incr_o     = (insn_i[13:8] == exec_pkg::OPC_INCR);
        is_branch_o   = (insn_i[13:11] == exec_pkg::OPC_BRANCH);
        dest_file_o   = insn_i[exec_pkg::DEST_BIT];
        faddr_o       = insn_i[6:0];
        imm_o         = insn_i[10:0];
    end

endmodule : insn_decode

`default_nettype wire

// [decskip_branch_incr_exec.sv]
// What this block does
// - Decrement-and-skip decrements file register, flags unchanged.
// - Destination bit 0 selects accumulator, 1 file.
// - Zero decrement result flushes next instruction, two cycles.
// - Branch loads eleven-bit immediate into PC low.
// - Branch copies latch bits 4:3 to PC 12:11.
// - Branch always takes two cycles, flushing fetch.
// - Increment adds one, single cycle, updates zero.
`timescale 1ns/1ps
`default_nettype none

module decskip_branch_incr_exec (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        insn_valid_i,
    input  wire logic [13:0] insn_i,
    input  wire logic [7:0]  file_rdata_i,
    input  wire logic [4:0]  program_counter_high_latch_i,
    input  wire logic        zero_flag_i,
    output logic [6:0]       file_addr_o,
    output logic             file_we_o,
    output logic [7:0]       file_wdata_o,
    output logic             acc_we_o,
    output logic [7:0]       acc_o,
    output logic             zero_we_o,
    output logic             zero_flag_o,
    output logic             pc_load_o,
    output logic [12:0]      pc_o,
    output logic             flush_o,
    output logic             busy_o
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic        is_dec_skip;
    logic        is_incr;
    logic        is_branch;
    logic        dest_file;
    logic [6:0]  faddr;
    logic [10:0] imm;

    insn_decode u_decode (
        .insn_i        (insn_i),
        .is_dec_skip_o (is_dec_skip),
        .is_incr_o     (is_incr),
        .is_branch_o   (is_branch),
        .dest_file_o   (dest_file),
        .faddr_o       (faddr),
        .imm_o         (imm)
    );

    // Read address is combinational so the register file answers in-cycle.
    // The write strobe trails this address by one cycle, so the register
    // file must keep the address of the taken slot for its write port.
    assign file_addr_o = faddr;

    // ------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------
    // Both results wrap modulo 256 by construction of the 8-bit width.
    function automatic logic [7:0] step(input logic [7:0] v, input logic up);
        step = up ? 8'(v + 8'h01) : 8'(v - 8'h01);
    endfunction : step

    logic       flush_r;
    logic       take;
    logic       do_dec;
    logic       do_inc;
    logic       do_br;
    logic [7:0] result;

    // An instruction in the flush slot is the discarded one and is ignored.
    always_comb begin
        take   = insn_valid_i && !flush_r;
        do_dec = take && is_dec_skip;
        do_inc = take && is_incr;
        do_br  = take && is_branch;
        result = step(file_rdata_i, is_incr);
    end

    // ------------------------------------------------------------------
    // Result write-back
    // ------------------------------------------------------------------
    // Destination steering; outputs are held in flops for clean timing.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            file_we_o    <= 1'b0;
            acc_we_o     <= 1'b0;
            file_wdata_o <= 8'h00;
            acc_o        <= exec_pkg::ACC_RST;
        end else begin
            file_we_o <= (do_dec || do_inc) && (dest_file == exec_pkg::DEST_FILE);
            acc_we_o  <= (do_dec || do_inc) && (dest_file == exec_pkg::DEST_ACC);
            if (do_dec || do_inc) begin
                file_wdata_o <= result;
                if (dest_file == exec_pkg::DEST_ACC) begin
                    acc_o <= result;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Zero flag
    // ------------------------------------------------------------------
    // Only increment touches the flag; decrement-and-skip leaves it alone.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            zero_we_o   <= 1'b0;
            zero_flag_o <= 1'b0;
        end else begin
            zero_we_o <= do_inc;
            if (do_inc) begin
                zero_flag_o <= (result == 8'h00);
            end else begin
                zero_flag_o <= zero_flag_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Program counter and flush
    // ------------------------------------------------------------------
    // The target is assembled from the immediate and two latch bits.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pc_load_o <= 1'b0;
            pc_o      <= exec_pkg::PC_RST;
        end else begin
            pc_load_o <= do_br;
            if (do_br) begin
                pc_o <= {program_counter_high_latch_i[exec_pkg::LATCH_HI:exec_pkg::LATCH_LO],
                         imm};
            end
        end
    end

    // A one-cycle flush turns the prefetched word into a no-operation,
    // which gives the second cycle of a taken skip and of every branch.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            flush_r <= 1'b0;
        end else begin
            flush_r <= do_br || (do_dec && (result == 8'h00));
        end
    end

    assign flush_o = flush_r;
    assign busy_o  = flush_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_DEC_NO_FLAG: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_dec |=> !zero_we_o)
        else $error("Decrement-and-skip wrote the zero flag.");

    AST_DEST_STEER: assert property (@(posedge mclk_i) disable iff (reset_i)
        (do_dec || do_inc) |=> (file_we_o == $past(dest_file)) && (acc_we_o != file_we_o))
        else $error("Result steered to the wrong destination.");

    AST_SKIP_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
        (do_dec && file_rdata_i == 8'h01) |=> flush_o ##1 !flush_o)
        else $error("Zero decrement did not flush exactly one slot.");

    AST_NO_SKIP: assert property (@(posedge mclk_i) disable iff (reset_i)
        (do_dec && file_rdata_i != 8'h01) |=> !flush_o)
        else $error("Nonzero decrement flushed the next slot.");

    AST_BR_LOW: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_br |=> pc_load_o && pc_o[10:0] == $past(insn_i[10:0]))
        else $error("Branch immediate not loaded into low counter bits.");

    AST_BR_HIGH: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_br |=> pc_o[12:11] == $past(program_counter_high_latch_i[4:3]))
        else $error("Branch upper counter bits not taken from latch.");

    AST_BR_TWO: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_br |=> flush_o && pc_load_o ##1 !flush_o && !pc_load_o)
        else $error("Branch did not occupy two cycles.");

    AST_INC_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_inc |=> zero_we_o && zero_flag_o == ($past(file_rdata_i) == 8'hFF))
        else $error("Increment zero flag wrong.");

    AST_INC_ONE: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_inc |=> !flush_o)
        else $error("Increment took more than one cycle.");

    // ------------------------------------------------------------------
    // Hold, slot and result checks
    // ------------------------------------------------------------------
    // A discarded slot must leave no trace on any strobe.
    AST_FLUSH_IGNORE: assert property (@(posedge mclk_i) disable iff (reset_i)
        flush_o |=> !file_we_o && !acc_we_o && !zero_we_o && !pc_load_o)
        else $error("Discarded slot produced a strobe.");

    // Only one slot is ever discarded, so a flush never repeats.
    AST_FLUSH_ONE: assert property (@(posedge mclk_i) disable iff (reset_i)
        flush_o |=> !flush_o)
        else $error("Flush lasted more than one slot.");

    // The decrement result wraps modulo 256.
    AST_DEC_RESULT: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_dec |=> file_wdata_o == 8'($past(file_rdata_i) - 8'h01))
        else $error("Decrement result wrong.");

    // The increment result wraps modulo 256.
    AST_INC_RESULT: assert property (@(posedge mclk_i) disable iff (reset_i)
        do_inc |=> file_wdata_o == 8'($past(file_rdata_i) + 8'h01))
        else $error("Increment result wrong.");

    // Without an increment the flag is only passed through, one cycle late.
    AST_ZERO_MIRROR: assert property (@(posedge mclk_i) disable iff (reset_i)
        !do_inc |=> zero_flag_o == $past(zero_flag_i))
        else $error("Zero flag changed without an increment.");

    // The branch target holds until the next branch is taken.
    AST_PC_HOLD: assert property (@(posedge mclk_i) disable iff (reset_i)
        !do_br |=> $stable(pc_o))
        else $error("Counter target moved without a branch.");

    // The accumulator changes only when a result is steered to it.
    AST_ACC_HOLD: assert property (@(posedge mclk_i) disable iff (reset_i)
        !((do_dec || do_inc) && dest_file == exec_pkg::DEST_ACC) |=> $stable(acc_o))
        else $error("Accumulator changed without a steered result.");

endmodule : decskip_branch_incr_exec

`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        insn_valid_i = 1'b0;
    logic [13:0] insn_i = 14'h0000;
    logic [7:0]  file_rdata_i = 8'h00;
    logic [4:0]  program_counter_high_latch_i = 5'h00;
    logic        zero_flag_i = 1'b0;
    logic [6:0]  file_addr_o;
    logic        file_we_o, acc_we_o, zero_we_o, zero_flag_o, pc_load_o, flush_o, busy_o;
    logic [7:0]  file_wdata_o, acc_o;
    logic [12:0] pc_o;
    int          miscompares = 0;
    int          num_checks = 0;

    decskip_branch_incr_exec dut_u (.mclk_i(mclk_i), .reset_i(reset_i),
        .insn_valid_i(insn_valid_i), .insn_i(insn_i), .file_rdata_i(file_rdata_i),
        .program_counter_high_latch_i(program_counter_high_latch_i),
        .zero_flag_i(zero_flag_i), .file_addr_o(file_addr_o), .file_we_o(file_we_o),
        .file_wdata_o(file_wdata_o), .acc_we_o(acc_we_o), .acc_o(acc_o),
        .zero_we_o(zero_we_o), .zero_flag_o(zero_flag_o), .pc_load_o(pc_load_o),
        .pc_o(pc_o), .flush_o(flush_o), .busy_o(busy_o));

    // Free-running 50 MHz instruction clock.
    always #10 mclk_i = ~mclk_i;

    // Every result is widened to the program counter width before comparing.
    task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Presents one slot; the following edge takes it.
    task automatic put(input logic v, input logic [13:0] w, input logic [7:0] rd);
        @(posedge mclk_i);
        insn_valid_i <= v;
        insn_i       <= w;
        file_rdata_i <= rd;
    endtask : put

    function automatic logic [13:0] op6(input logic [5:0] opc, input logic d, input logic [6:0] f);
        return {opc, d, f};
    endfunction : op6

    task automatic test_dec();
        zero_flag_i <= 1'b1;
        put(1'b1, op6(exec_pkg::OPC_DEC_SKIP, 1'b1, 7'h25), 8'h05);
        #1 chk("file_addr", 13'h0025, 13'(file_addr_o));
        put(1'b1, op6(exec_pkg::OPC_DEC_SKIP, 1'b1, 7'h26), 8'h00);
        #1 chk("file_we", 13'h0001, 13'(file_we_o));
        chk("file_wdata", 13'h0004, 13'(file_wdata_o));
        chk("acc_we", 13'h0000, 13'(acc_we_o));
        chk("zero_we", 13'h0000, 13'(zero_we_o));
        chk("zero_flag", 13'h0001, 13'(zero_flag_o));
        chk("flush", 13'h0000, 13'(flush_o));
        // Wrap from zero gives FF, which is not a skip.
        put(1'b1, op6(exec_pkg::OPC_DEC_SKIP, 1'b0, 7'h27), 8'h01);
        #1 chk("wrap_wdata", 13'h00FF, 13'(file_wdata_o));
        chk("wrap_flush", 13'h0000, 13'(flush_o));
        // The increment offered in the flushed slot must vanish.
        put(1'b1, op6(exec_pkg::OPC_INCR, 1'b0, 7'h28), 8'hFF);
        #1 chk("skip_acc_we", 13'h0001, 13'(acc_we_o));
        chk("skip_acc", 13'h0000, 13'(acc_o));
        chk("skip_flush", 13'h0001, 13'(flush_o));
        chk("skip_busy", 13'h0001, 13'(busy_o));
        chk("skip_zero_we", 13'h0000, 13'(zero_we_o));
        put(1'b0, 14'h0000, 8'h00);
        #1 chk("slot_acc_we", 13'h0000, 13'(acc_we_o));
        chk("slot_zero_we", 13'h0000, 13'(zero_we_o));
        chk("slot_flush", 13'h0000, 13'(flush_o));
        $display("test_dec done");
    endtask : test_dec

    task automatic test_branch(input logic [4:0] latch, input logic [10:0] k);
        put(1'b1, {exec_pkg::OPC_BRANCH, k}, 8'h00);
        program_counter_high_latch_i <= latch;
        put(1'b1, op6(exec_pkg::OPC_DEC_SKIP, 1'b1, 7'h10), 8'h09);
        #1 chk("pc_load", 13'h0001, 13'(pc_load_o));
        chk("pc", {latch[4:3], k}, pc_o);
        chk("br_flush", 13'h0001, 13'(flush_o));
        put(1'b0, 14'h0000, 8'h00);
        #1 chk("br_slot_we", 13'h0000, 13'(file_we_o));
        chk("br_pc_load", 13'h0000, 13'(pc_load_o));
        chk("br_pc_hold", {latch[4:3], k}, pc_o);
        $display("test_branch done");
    endtask : test_branch

    task automatic test_incr();
        put(1'b1, op6(exec_pkg::OPC_INCR, 1'b0, 7'h33), 8'hFF);
        zero_flag_i <= 1'b0;
        put(1'b1, op6(exec_pkg::OPC_INCR, 1'b1, 7'h34), 8'h7F);
        #1 chk("inc_acc_we", 13'h0001, 13'(acc_we_o));
        chk("inc_acc", 13'h0000, 13'(acc_o));
        chk("inc_zero_we", 13'h0001, 13'(zero_we_o));
        chk("inc_zero", 13'h0001, 13'(zero_flag_o));
        chk("inc_flush", 13'h0000, 13'(flush_o));
        put(1'b0, 14'h0000, 8'h00);
        #1 chk("inc_file_we", 13'h0001, 13'(file_we_o));
        chk("inc_wdata", 13'h0080, 13'(file_wdata_o));
        chk("inc_zero2", 13'h0000, 13'(zero_flag_o));
        chk("inc_acc_we2", 13'h0000, 13'(acc_we_o));
        $display("test_incr done");
    endtask : test_incr

    // Invalid slots and neighbouring opcodes must leave every strobe low.
    task automatic test_other();
        put(1'b0, op6(exec_pkg::OPC_DEC_SKIP, 1'b1, 7'h11), 8'h01);
        put(1'b1, op6(6'h03, 1'b0, 7'h12), 8'h01);
        #1 chk("oth_inv_we", 13'h0000, 13'(file_we_o));
        chk("oth_inv_flush", 13'h0000, 13'(flush_o));
        put(1'b1, op6(6'h09, 1'b1, 7'h13), 8'h00);
        #1 chk("oth_dec_acc_we", 13'h0000, 13'(acc_we_o));
        chk("oth_dec_flush", 13'h0000, 13'(flush_o));
        put(1'b1, {3'h4, 11'h055}, 8'h00);
        #1 chk("oth_cpl_we", 13'h0000, 13'(file_we_o));
        chk("oth_cpl_zero_we", 13'h0000, 13'(zero_we_o));
        put(1'b0, 14'h0000, 8'h00);
        #1 chk("oth_pc_load", 13'h0000, 13'(pc_load_o));
        chk("oth_br_flush", 13'h0000, 13'(flush_o));
        $display("test_other done");
    endtask : test_other

    // Reset in mid-run drops an offered branch, then work resumes.
    task automatic test_reset();
        put(1'b1, {exec_pkg::OPC_BRANCH, 11'h123}, 8'h00);
        reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1 chk("rst_pc", exec_pkg::PC_RST, pc_o);
        chk("rst_pc_load", 13'h0000, 13'(pc_load_o));
        chk("rst_flush", 13'h0000, 13'(flush_o));
        chk("rst_acc", 13'(exec_pkg::ACC_RST), 13'(acc_o));
        chk("rst_wdata", 13'h0000, 13'(file_wdata_o));
        chk("rst_zero_we", 13'h0000, 13'(zero_we_o));
        put(1'b0, 14'h0000, 8'h00);
        reset_i <= 1'b0;
        put(1'b1, op6(exec_pkg::OPC_INCR, 1'b0, 7'h01), 8'h41);
        #1 chk("rel_acc_we", 13'h0000, 13'(acc_we_o));
        put(1'b0, 14'h0000, 8'h00);
        #1 chk("rel_acc", 13'h0042, 13'(acc_o));
        chk("rel_zero", 13'h0000, 13'(zero_flag_o));
        $display("test_reset done");
    endtask : test_reset

    task automatic test_done();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    // Main sequence: reset for five edges, then each scenario in turn.
    initial begin
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'b0;
        test_dec();
        test_branch(5'h18, 11'h5A5);
        test_branch(5'h07, 11'h7FF);
        test_incr();
        test_other();
        test_reset();
        test_done();
    end

    // The scenarios need well under a hundred cycles, so this is generous.
    initial begin
        repeat (2000) @(posedge mclk_i);
        miscompares++;
        test_done();
    end
endmodule : tb

`default_nettype wire
